// file: hw/dtg_cfg.svh
`ifndef DTG_CFG_SVH
`define DTG_CFG_SVH
`define DTG_CK_PS 5000
`define DTG_CYC(ps) (((ps) + `DTG_CK_PS - 1) / `DTG_CK_PS)
`define DTG_MAX(a, b) (((a) > (b)) ? (a) : (b))
`define DTG_T_RRD_PS 7500
`define DTG_RRD_CYC `DTG_MAX(4, `DTG_CYC(`DTG_T_RRD_PS))
`define DTG_T_FAW_PS 40000
`define DTG_FAW_CYC `DTG_CYC(`DTG_T_FAW_PS)
`define DTG_T_WTR_PS 7500
`define DTG_WTR_CYC `DTG_MAX(4, `DTG_CYC(`DTG_T_WTR_PS))
`define DTG_T_RTP_PS 7500
`define DTG_RTP_CYC `DTG_MAX(4, `DTG_CYC(`DTG_T_RTP_PS))
`define DTG_T_WR_PS 15000
`define DTG_WR_CYC `DTG_CYC(`DTG_T_WR_PS)
`define DTG_T_RP_PS 15000
`define DTG_DAL_CYC (`DTG_WR_CYC + `DTG_CYC(`DTG_T_RP_PS))
`define DTG_MRD_CYC 4
`define DTG_T_MOD_PS 15000
`define DTG_MOD_CYC `DTG_MAX(12, `DTG_CYC(`DTG_T_MOD_PS))
`define DTG_MPRR_CYC 1
`define DTG_ZQINIT_CYC 512
`define DTG_ZQOPER_CYC 256
`define DTG_ZQCS_CYC 64
`define DTG_T_RFC_PS 110000
`define DTG_RFC_CYC `DTG_CYC(`DTG_T_RFC_PS)
`define DTG_T_XPR_EXTRA_PS 10000
`define DTG_XPR_CYC `DTG_MAX(5, `DTG_CYC(`DTG_T_RFC_PS + `DTG_T_XPR_EXTRA_PS))
`define DTG_XS_CYC `DTG_XPR_CYC
`define DTG_DLLK_CYC 512
`define DTG_T_CKE_PS 7500
`define DTG_CKE_CYC `DTG_MAX(3, `DTG_CYC(`DTG_T_CKE_PS))
`define DTG_CKESR_CYC (`DTG_CKE_CYC + 1)
`define DTG_T_CKSR_PS 10000
`define DTG_CKSR_CYC `DTG_MAX(5, `DTG_CYC(`DTG_T_CKSR_PS))
`define DTG_T_XP_PS 7500
`define DTG_XP_CYC `DTG_MAX(3, `DTG_CYC(`DTG_T_XP_PS))
`define DTG_T_XPDLL_PS 24000
`define DTG_XPDLL_CYC `DTG_MAX(10, `DTG_CYC(`DTG_T_XPDLL_PS))
`define DTG_ODTH_LONG 6
`define DTG_ODTH_SHORT 4
`define DTG_BURST_HALF 4
`define DTG_CHOP_HALF 2
`define DTG_T_REFI_PS 7800000
`define DTG_REFI_CYC `DTG_CYC(`DTG_T_REFI_PS)
`define DTG_REF_MAX_OWED 9
`define DTG_CKE_SAT 4'hf
`define DTG_SINCE_SAT 10'h3ff
`endif

// file: hw/dtg_pkg.sv
`default_nettype none
package dtg_pkg;
  typedef logic [9:0] dtg_cnt_t;
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0, CMD_ACT = 4'h1, CMD_RD = 4'h2, CMD_WR = 4'h3,
    CMD_PRE = 4'h4, CMD_PREA = 4'h5, CMD_REF = 4'h6, CMD_MRS = 4'h7,
    CMD_ZQCL = 4'h8, CMD_ZQCS = 4'h9, CMD_SRE = 4'ha, CMD_SRX = 4'hb,
    CMD_PDE = 4'hc, CMD_PDX = 4'hd
  } dtg_cmd_t;
  typedef enum logic [2:0] {
    ST_INIT = 3'h0, ST_RUN = 3'h1, ST_PD = 3'h3, ST_SREF = 3'h2, ST_WAKE = 3'h6
  } dtg_state_t;
endpackage
`default_nettype wire

// file: hw/dtg_timing_guard.sv
`timescale 1ns/1ps
`default_nettype none
`include "dtg_cfg.svh"
// Operation
// [RULE1] activates to different banks spaced by activate gap, at least four cycles
// [RULE2] at most four activates inside any rolling four-activate window
// [RULE3] read waits write-to-read gap after the write burst ends
// [RULE4] precharge waits read-to-precharge gap after a read to that bank
// [RULE5] write with auto-precharge blocks its bank for write recovery plus precharge
// [RULE6] two mode register sets at least four cycles apart
// [RULE7] other commands wait the mode register update delay after a set
// [RULE8] one cycle between multipurpose read burst end and exiting mode set
// [RULE9] long calibration holds all commands 512 cycles first, then 256
// [RULE10] short calibration holds all commands for 64 cycles
// [RULE11] after clock enable rises on reset exit, wait reset exit time
// [RULE12] refresh then 110 ns before activate or refresh; at most nine intervals owed
// [RULE13] self-refresh exit waits exit time before non-lock commands
// [RULE14] self-refresh exit waits full loop lock time before reads
// [RULE15] clock enable stays low in self-refresh at least minimum pulse plus one
// [RULE16] clock kept valid after low-power entry and restored before exit
// [RULE17] clock enable high or low pulses last at least minimum pulse width
// [RULE18] power-down may follow activate, precharge or refresh after one cycle; here entry after refresh also waits the refresh cycle time
// [RULE19] power-down after read waits read latency plus five cycles
// [RULE20] power-down after write waits latency, burst, recovery, plus one with auto-precharge
// [RULE21] power-down exit waits exit time; lock commands wait longer after dll-off
// [RULE22] termination stays high six cycles, four with chopped write
// [RULE23] time minimums converted to cycles round up
// [RULE24] device delays auto-precharge until activate-to-precharge time met
// [RULE25] keep per-bank and global records of last command times
module dtg_timing_guard
  import dtg_pkg::*;
#(
  parameter int RL = 11,
  parameter int WL = 8,
  parameter int NBANK = 8,
  parameter int REFI_CYC = `DTG_REFI_CYC,
  parameter int REF_LIMIT_CYC = `DTG_REF_MAX_OWED * `DTG_REFI_CYC
)(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic req_valid,
  input wire dtg_cmd_t req_cmd,
  input wire logic [$clog2(NBANK)-1:0] req_bank,
  input wire logic req_ap,
  input wire logic req_bc4,
  input wire logic odt_req,
  input wire logic pd_dll_off,
  output logic req_ready,
  output dtg_cmd_t ddr_cmd_q,
  output logic [$clog2(NBANK)-1:0] ddr_bank_q,
  output logic ddr_ap_q,
  output logic ddr_cke_q,
  output logic ddr_ck_en_q,
  output logic ddr_odt_q,
  output logic ref_due_q,
  output logic ref_urgent_q
);
  localparam int BW = $clog2(NBANK);

  // [RULE23] rounded-up cycle counts
  // the cycle macros round every time minimum up, so gap() only shifts by the take edge

  function automatic dtg_cnt_t gap(input int n);
    gap = dtg_cnt_t'((n > 1) ? n - 1 : 0);
  endfunction

  function automatic dtg_cnt_t dec(input dtg_cnt_t c);
    dec = (c == '0) ? '0 : c - dtg_cnt_t'(1);
  endfunction

  // keep the later of a running wait and a new one
  function automatic dtg_cnt_t later(input dtg_cnt_t c, input int n);
    later = (gap(n) > dec(c)) ? gap(n) : dec(c);
  endfunction

  dtg_state_t state_q;
  logic acc;
  logic ok;
  logic wake_sr_q;
  logic dll_off_q;
  logic zq_done_q;
  logic [3:0] cke_cnt_q;
  dtg_cnt_t busy_q, rrd_q, wtr_q, mrd_q, mod_q, mpr_q, rfc_q;
  dtg_cnt_t exit_q, lock_q, pde_q, cksr_q, odth_q;
  dtg_cnt_t faw_q [4];
  logic [1:0] faw_ptr_q;
  dtg_cnt_t rtp_q [NBANK];
  dtg_cnt_t dal_q [NBANK];
  logic [NBANK-1:0] rtp_free, dal_free;
  logic [15:0] ref_cnt_q;

  assign acc = req_valid && req_ready;
  assign req_ready = ok;

  // [RULE25] per-bank records
  for (genvar b = 0; b < NBANK; b++)
  begin : g_bank
    logic hit;
    assign hit = acc && (req_bank == BW'(b));
    assign rtp_free[b] = (rtp_q[b] == '0);
    assign dal_free[b] = (dal_q[b] == '0);
    always_ff @(posedge sys_clk or negedge nrst)
    begin
      if (!nrst)
      begin
        rtp_q[b] <= '0;
        dal_q[b] <= '0;
      end
      else
      begin
        // [RULE4] read to precharge
        rtp_q[b] <= (hit && req_cmd == CMD_RD) ? later(rtp_q[b], `DTG_RTP_CYC) : dec(rtp_q[b]);
        // [RULE5] auto-precharge recovery
        if (hit && req_cmd == CMD_WR && req_ap)
          dal_q[b] <= later(dal_q[b], WL + `DTG_BURST_HALF + `DTG_DAL_CYC);
        else
          dal_q[b] <= dec(dal_q[b]);
      end
    end
  end

  always_comb
  begin
    logic g;
    g = (busy_q == '0) && (exit_q == '0);
    ok = 1'b0;
    case (state_q)
      ST_RUN:
        case (req_cmd)
          CMD_NOP: ok = 1'b1;
          // [RULE1] [RULE2] activate spacing
          CMD_ACT: ok = g && rrd_q == '0 && faw_q[faw_ptr_q] == '0 && rfc_q == '0
                        && mod_q == '0 && dal_free[req_bank];
          // [RULE3] [RULE14] reads wait write gap and lock
          CMD_RD: ok = g && wtr_q == '0 && lock_q == '0 && mod_q == '0;
          CMD_WR: ok = g && mod_q == '0;
          CMD_PRE: ok = g && mod_q == '0 && rtp_free[req_bank] && dal_free[req_bank];
          CMD_PREA: ok = g && mod_q == '0 && &rtp_free && &dal_free;
          // [RULE12] refresh cycle time
          CMD_REF: ok = g && rfc_q == '0 && mod_q == '0 && &dal_free;
          // [RULE6] [RULE8] mode set spacing
          CMD_MRS: ok = g && mrd_q == '0 && mpr_q == '0;
          CMD_ZQCL, CMD_ZQCS: ok = g && mod_q == '0;
          // [RULE17] clock enable pulse before entry
          CMD_SRE, CMD_PDE: ok = g && pde_q == '0 && mod_q == '0 && rfc_q == '0
                                && cke_cnt_q >= 4'(`DTG_CKE_CYC);
          default: ok = 1'b0;
        endcase
      // [RULE15] self-refresh low time
      ST_SREF: ok = (req_cmd == CMD_SRX) && cke_cnt_q >= 4'(`DTG_CKESR_CYC);
      ST_PD: ok = (req_cmd == CMD_PDX) && cke_cnt_q >= 4'(`DTG_CKE_CYC);
      default: ok = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= ST_INIT;
      wake_sr_q <= 1'b0;
      dll_off_q <= 1'b0;
    end
    else
      case (state_q)
        ST_INIT: if (cksr_q == '0) state_q <= ST_RUN;
        ST_RUN:
        begin
          if (acc && req_cmd == CMD_SRE) state_q <= ST_SREF;
          if (acc && req_cmd == CMD_PDE)
          begin
            state_q <= ST_PD;
            dll_off_q <= pd_dll_off;
          end
        end
        ST_SREF, ST_PD:
        begin
          if (acc)
          begin
            state_q <= ST_WAKE;
            wake_sr_q <= (state_q == ST_SREF);
          end
        end
        ST_WAKE: if (cksr_q == '0) state_q <= ST_RUN;
        default: state_q <= ST_INIT;
      endcase
  end

  // clock enable pin and its pulse width
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ddr_cke_q <= 1'b0;
      cke_cnt_q <= '0;
    end
    else if ((state_q == ST_INIT || state_q == ST_WAKE) && cksr_q == '0)
    begin
      ddr_cke_q <= 1'b1;
      cke_cnt_q <= '0;
    end
    else if (acc && (req_cmd == CMD_SRE || req_cmd == CMD_PDE))
    begin
      ddr_cke_q <= 1'b0;
      cke_cnt_q <= '0;
    end
    else if (cke_cnt_q != `DTG_CKE_SAT)
      cke_cnt_q <= cke_cnt_q + 4'h1;
  end

  // [RULE16] clock hold after entry, valid before exit
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cksr_q <= dtg_cnt_t'(`DTG_CKSR_CYC - 1);
      ddr_ck_en_q <= 1'b1;
    end
    else
    begin
      if (acc && (req_cmd == CMD_SRE || req_cmd == CMD_PDE || req_cmd == CMD_SRX
                  || req_cmd == CMD_PDX))
        cksr_q <= gap(`DTG_CKSR_CYC);
      else
        cksr_q <= dec(cksr_q);
      if (acc && (req_cmd == CMD_SRX || req_cmd == CMD_PDX))
        ddr_ck_en_q <= 1'b1;
      else if ((state_q == ST_SREF || state_q == ST_PD) && cksr_q == '0)
        ddr_ck_en_q <= 1'b0;
    end
  end

  // command bus waits
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_q <= '0;
      rrd_q <= '0;
      wtr_q <= '0;
      mrd_q <= '0;
      mod_q <= '0;
      mpr_q <= '0;
      rfc_q <= '0;
    end
    else
    begin
      // [RULE11] reset exit wait
      if (state_q == ST_INIT && cksr_q == '0)
        busy_q <= later(busy_q, `DTG_XPR_CYC);
      // [RULE9] long calibration, longer first time
      else if (acc && req_cmd == CMD_ZQCL)
        busy_q <= later(busy_q, zq_done_q ? `DTG_ZQOPER_CYC : `DTG_ZQINIT_CYC);
      // [RULE10] short calibration
      else if (acc && req_cmd == CMD_ZQCS)
        busy_q <= later(busy_q, `DTG_ZQCS_CYC);
      else
        busy_q <= dec(busy_q);
      rrd_q <= (acc && req_cmd == CMD_ACT) ? gap(`DTG_RRD_CYC) : dec(rrd_q);
      // [RULE3] burst end then write-to-read gap
      if (acc && req_cmd == CMD_WR)
        wtr_q <= later(wtr_q, WL + (req_bc4 ? `DTG_CHOP_HALF : `DTG_BURST_HALF)
                       + `DTG_WTR_CYC);
      else
        wtr_q <= dec(wtr_q);
      // [RULE6] [RULE7] mode set cycle and update
      mrd_q <= (acc && req_cmd == CMD_MRS) ? gap(`DTG_MRD_CYC) : dec(mrd_q);
      mod_q <= (acc && req_cmd == CMD_MRS) ? gap(`DTG_MOD_CYC) : dec(mod_q);
      // [RULE8] read burst end to mode set
      if (acc && req_cmd == CMD_RD)
        mpr_q <= later(mpr_q, RL + `DTG_BURST_HALF + `DTG_MPRR_CYC);
      else
        mpr_q <= dec(mpr_q);
      // [RULE12] refresh cycle time
      rfc_q <= (acc && req_cmd == CMD_REF) ? gap(`DTG_RFC_CYC) : dec(rfc_q);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      zq_done_q <= 1'b0;
    else if (acc && req_cmd == CMD_ZQCL)
      zq_done_q <= 1'b1;
  end

  // [RULE2] oldest of the last four activates
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      faw_ptr_q <= '0;
      for (int i = 0; i < 4; i++) faw_q[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
        faw_q[i] <= (acc && req_cmd == CMD_ACT && faw_ptr_q == 2'(i))
                    ? gap(`DTG_FAW_CYC) : dec(faw_q[i]);
      if (acc && req_cmd == CMD_ACT) faw_ptr_q <= faw_ptr_q + 2'h1;
    end
  end

  // low-power entry and exit waits
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pde_q <= '0;
      exit_q <= '0;
      lock_q <= '0;
    end
    else
    begin
      if (acc)
        case (req_cmd)
          // [RULE18] one cycle after these
          CMD_ACT, CMD_PRE, CMD_PREA, CMD_REF: pde_q <= later(pde_q, 1);
          // [RULE19] read to power-down
          CMD_RD: pde_q <= later(pde_q, RL + `DTG_BURST_HALF + 1);
          // [RULE20] write to power-down
          CMD_WR: pde_q <= later(pde_q, WL + (req_bc4 ? `DTG_CHOP_HALF : `DTG_BURST_HALF)
                                 + `DTG_WR_CYC + (req_ap ? 1 : 0));
          CMD_MRS: pde_q <= later(pde_q, `DTG_MOD_CYC);
          default: pde_q <= dec(pde_q);
        endcase
      else
        pde_q <= dec(pde_q);
      if (state_q == ST_WAKE && cksr_q == '0)
      begin
        // [RULE13] [RULE21] exit waits
        exit_q <= wake_sr_q ? gap(`DTG_XS_CYC) : gap(`DTG_XP_CYC);
        // [RULE14] [RULE21] lock waits for reads
        lock_q <= wake_sr_q ? gap(`DTG_DLLK_CYC) : (dll_off_q ? gap(`DTG_XPDLL_CYC) : '0);
      end
      else
      begin
        exit_q <= dec(exit_q);
        lock_q <= dec(lock_q);
      end
    end
  end

  // [RULE22] termination high time
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ddr_odt_q <= 1'b0;
      odth_q <= '0;
    end
    else
    begin
      ddr_odt_q <= odt_req || (odth_q != '0);
      if (odt_req && !ddr_odt_q)
        odth_q <= gap(`DTG_ODTH_LONG);
      else if (acc && req_cmd == CMD_WR && ddr_odt_q)
        odth_q <= later(odth_q, req_bc4 ? `DTG_ODTH_SHORT : `DTG_ODTH_LONG);
      else
        odth_q <= dec(odth_q);
    end
  end

  // [RULE12] refresh owed; the device refreshes itself in self-refresh
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ref_cnt_q <= '0;
      ref_due_q <= 1'b0;
      ref_urgent_q <= 1'b0;
    end
    else
    begin
      if ((acc && req_cmd == CMD_REF) || state_q == ST_SREF)
        ref_cnt_q <= '0;
      else if (ref_cnt_q != 16'hffff)
        ref_cnt_q <= ref_cnt_q + 16'h1;
      ref_due_q <= ref_cnt_q >= 16'(REFI_CYC);
      ref_urgent_q <= ref_cnt_q >= 16'(REF_LIMIT_CYC - REFI_CYC);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ddr_cmd_q <= CMD_NOP;
      ddr_bank_q <= '0;
      ddr_ap_q <= 1'b0;
    end
    else
    begin
      ddr_cmd_q <= acc ? req_cmd : CMD_NOP;
      ddr_bank_q <= acc ? req_bank : ddr_bank_q;
      ddr_ap_q <= acc && req_ap;
    end
  end

  // cycles since each command last went out, for checking only
  logic [9:0] since_q [16];
  for (genvar c = 0; c < 16; c++)
  begin : g_since
    always_ff @(posedge sys_clk or negedge nrst)
    begin
      if (!nrst)
        since_q[c] <= `DTG_SINCE_SAT;
      else if (ddr_cmd_q == dtg_cmd_t'(c))
        since_q[c] <= 10'h1;
      else if (since_q[c] != `DTG_SINCE_SAT)
        since_q[c] <= since_q[c] + 10'h1;
    end
  end

  localparam int A_RRD = `DTG_RRD_CYC;
  localparam int A_WTR = WL + `DTG_CHOP_HALF + `DTG_WTR_CYC;
  localparam int A_MRD = `DTG_MRD_CYC;
  localparam int A_MOD = `DTG_MOD_CYC;
  localparam int A_RFC = `DTG_RFC_CYC;
  localparam int A_ZQS = `DTG_ZQCS_CYC;
  localparam int A_ZQL = `DTG_ZQOPER_CYC;
  localparam int A_RDPD = RL + `DTG_BURST_HALF + 1;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence cke_edge_s;
    $changed(ddr_cke_q);
  endsequence
  sequence cke_hold_s;
    $stable(ddr_cke_q) [*2];
  endsequence

  act_gap_a: assert property (ddr_cmd_q == CMD_ACT |-> since_q[CMD_ACT] >= A_RRD) // [RULE1]
    else $error("activates too close");
  wr_rd_a: assert property (ddr_cmd_q == CMD_RD |-> since_q[CMD_WR] >= A_WTR) // [RULE3]
    else $error("read too soon after write");
  mrs_gap_a: assert property (ddr_cmd_q == CMD_MRS |-> since_q[CMD_MRS] >= A_MRD) // [RULE6]
    else $error("mode sets too close");
  mod_wait_a: assert property ((ddr_cmd_q != CMD_NOP && ddr_cmd_q != CMD_MRS) // [RULE7]
    |-> since_q[CMD_MRS] >= A_MOD) else $error("command inside mode update delay");
  zq_long_a: assert property (ddr_cmd_q != CMD_NOP |-> since_q[CMD_ZQCL] >= A_ZQL) // [RULE9]
    else $error("command during long calibration");
  zq_short_a: assert property (ddr_cmd_q != CMD_NOP |-> since_q[CMD_ZQCS] >= A_ZQS) // [RULE10]
    else $error("command during short calibration");
  ref_gap_a: assert property ((ddr_cmd_q == CMD_ACT || ddr_cmd_q == CMD_REF) // [RULE12]
    |-> since_q[CMD_REF] >= A_RFC) else $error("refresh cycle time broken");
  rd_pd_a: assert property (ddr_cmd_q == CMD_PDE |-> since_q[CMD_RD] >= A_RDPD) // [RULE19]
    else $error("power-down too soon after read");
  cke_pulse_a: assert property (cke_edge_s |=> cke_hold_s) // [RULE17]
    else $error("clock enable pulse too short");
  sref_low_a: assert property ($fell(ddr_cke_q) && state_q == ST_SREF // [RULE15]
    |-> !ddr_cke_q [*5]) else $error("self-refresh low time short");
  clk_hold_a: assert property ($fell(ddr_cke_q) |-> ddr_ck_en_q [*5]) // [RULE16]
    else $error("clock stopped too early");
  odt_high_a: assert property ($rose(ddr_odt_q) |-> ddr_odt_q [*4]) // [RULE22]
    else $error("termination high too short");
endmodule
`default_nettype wire

// file: sim/dtg_ddr_model.sv
`timescale 1ns/1ps
`default_nettype none
module dtg_ddr_model
  import dtg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire dtg_cmd_t mem_cmd,
  input wire logic mem_cke,
  input wire logic mem_ck_en,
  output int bad_cnt
);
  int busy_q;
  int since_act_q;
  int since_mrs_q;
  int since_ref_q;
  logic zq_first_q;
  logic cmd_on;
  assign cmd_on = (mem_cmd != CMD_NOP);
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      busy_q <= 0;
    else if (mem_cmd == CMD_ZQCL)
      busy_q <= zq_first_q ? 511 : 255;
    else if (mem_cmd == CMD_ZQCS)
      busy_q <= 63;
    else if (busy_q > 0)
      busy_q <= busy_q - 1;
  end
  // only the first long calibration after reset takes the init time
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      zq_first_q <= 1'b1;
    else if (mem_cmd == CMD_ZQCL)
      zq_first_q <= 1'b0;
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      since_act_q <= 1000;
      since_mrs_q <= 1000;
      since_ref_q <= 1000;
    end
    else
    begin
      // activate record, for the activate spacing check
      since_act_q <= (mem_cmd == CMD_ACT) ? 1 : since_act_q + 1;
      since_mrs_q <= (mem_cmd == CMD_MRS) ? 1 : since_mrs_q + 1;
      since_ref_q <= (mem_cmd == CMD_REF) ? 1 : since_ref_q + 1;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      bad_cnt <= 0;
    else
      bad_cnt <= bad_cnt + int'(cmd_on && busy_q > 0)
        + int'(mem_cmd == CMD_ACT && since_act_q < 4)
        + int'(mem_cmd == CMD_MRS && since_mrs_q < 4)
        + int'(cmd_on && mem_cmd != CMD_MRS && since_mrs_q < 12)
        + int'((mem_cmd == CMD_ACT || mem_cmd == CMD_REF) && since_ref_q < 22)
        + int'(mem_cke && !mem_ck_en);
  end
endmodule
`default_nettype wire

// file: sim/ddr3_command_timing_guard_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ddr3_command_timing_guard_tb_top
  import dtg_pkg::*;
;
  localparam int WLC = 8;
  localparam int RLC = 11;
  localparam int REFI = 40;
  localparam int REFLIM = 360;
  typedef struct {dtg_cmd_t c; logic [2:0] b; logic ap; int t;} dtg_note_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  dtg_cmd_t req_cmd = CMD_NOP;
  logic [2:0] req_bank = 3'h0;
  logic req_ap = 1'b0;
  logic req_bc4 = 1'b0;
  logic odt_req = 1'b0;
  logic pd_dll_off = 1'b0;
  logic req_ready;
  dtg_cmd_t ddr_cmd_q;
  logic [2:0] ddr_bank_q;
  logic ddr_ap_q, ddr_cke_q, ddr_ck_en_q, ddr_odt_q, ref_due_q, ref_urgent_q;
  int bad_cnt;
  int cyc = 0;
  int last_t = 0;
  int n_errors = 0;
  int checks = 0;
  logic [31:0] rnd = 32'h0000003b;
  dtg_note_t q[$];

  dtg_timing_guard #(.RL(RLC), .WL(WLC), .NBANK(8), .REFI_CYC(REFI), .REF_LIMIT_CYC(REFLIM)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_bank(req_bank), .req_ap(req_ap), .req_bc4(req_bc4), .odt_req(odt_req),
    .pd_dll_off(pd_dll_off), .req_ready(req_ready), .ddr_cmd_q(ddr_cmd_q),
    .ddr_bank_q(ddr_bank_q), .ddr_ap_q(ddr_ap_q), .ddr_cke_q(ddr_cke_q),
    .ddr_ck_en_q(ddr_ck_en_q), .ddr_odt_q(ddr_odt_q), .ref_due_q(ref_due_q),
    .ref_urgent_q(ref_urgent_q));

  dtg_ddr_model u_mem (.sys_clk(sys_clk), .nrst(nrst), .mem_cmd(ddr_cmd_q),
    .mem_cke(ddr_cke_q), .mem_ck_en(ddr_ck_en_q), .bad_cnt(bad_cnt));

  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic note(input string s);
    $display("test %s done, checks %0d errors %0d", s, checks, n_errors);
  endtask

  // gap > 0 asks the exact spacing, gap < 0 a floor; the request is held until taken
  task automatic issue(input dtg_cmd_t c, input logic [2:0] b, input logic ap,
                       input logic bc4, input int gap);
    int w;
    w = 0;
    @(posedge sys_clk);
    #1;
    req_cmd = c;
    req_bank = b;
    req_ap = ap;
    req_bc4 = bc4;
    req_valid = 1'b1;
    do
    begin
      @(negedge sys_clk);
      w++;
    end
    while (req_ready !== 1'b1 && w < 4000);
    chk("ready_wait", 1, w < 4000);
    @(posedge sys_clk);
    #1;
    req_valid = 1'b0;
    req_cmd = CMD_NOP;
    if (gap > 0)
      chk("gap", gap, cyc - last_t);
    if (gap < 0)
      chk("gap_min", 1, (cyc - last_t) >= -gap);
    last_t = cyc;
    q.push_back('{c, b, ap, cyc});
  endtask

  // every issued command must match the oldest note, in the cycle after its taking edge
  always @(negedge sys_clk)
  begin
    dtg_note_t e;
    if (nrst === 1'b1 && ddr_cmd_q !== CMD_NOP)
    begin
      if (q.size() == 0)
        chk("unexpected_cmd", CMD_NOP, ddr_cmd_q);
      else
      begin
        e = q.pop_front();
        chk("cmd", e.c, ddr_cmd_q);
        chk("bank", e.b, ddr_bank_q);
        chk("ap", e.ap, ddr_ap_q);
        chk("issue_cycle", e.t, cyc);
      end
    end
  end

  // whole run is a few thousand cycles; 20000 leaves ample margin
  initial
  begin
    #100000;
    n_errors++;
    $display("watchdog expired");
    results();
  end

  initial
  begin
    int i;
    int n;
    logic [2:0] bk;
    bk = 3'h0;
    repeat (16) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    issue(CMD_ZQCL, 3'h0, 1'b0, 1'b0, 0);
    chk("cke_after_reset", 1, ddr_cke_q);
    issue(CMD_ACT, 3'h0, 1'b0, 1'b0, 512);
    issue(CMD_ZQCL, 3'h0, 1'b0, 1'b0, 0);
    issue(CMD_ACT, 3'h1, 1'b0, 1'b0, 256);
    issue(CMD_ZQCS, 3'h0, 1'b0, 1'b0, 0);
    issue(CMD_ACT, 3'h2, 1'b0, 1'b0, 64);
    note("calibration");
    issue(CMD_MRS, 3'h0, 1'b0, 1'b0, 0);
    issue(CMD_MRS, 3'h1, 1'b0, 1'b0, 4);
    issue(CMD_ACT, 3'h3, 1'b0, 1'b0, 12);
    for (i = 0; i < 5; i++)
    begin
      rnd = xs(rnd);
      bk = bk + 3'h1 + {1'b0, rnd[1:0]};
      issue(CMD_ACT, bk, 1'b0, 1'b0, 4);
    end
    issue(CMD_RD, bk, 1'b0, 1'b0, 0);
    issue(CMD_PRE, bk, 1'b0, 1'b0, 4);
    for (i = 0; i < 2; i++)
    begin
      issue(CMD_WR, 3'h1, 1'b0, i[0], 0);
      issue(CMD_RD, 3'h1, 1'b0, 1'b0, WLC + ((i == 1) ? 2 : 4) + 4);
    end
    issue(CMD_WR, 3'h2, 1'b1, 1'b0, 0);
    issue(CMD_ACT, 3'h2, 1'b0, 1'b0, WLC + 4 + 6);
    issue(CMD_RD, 3'h3, 1'b0, 1'b0, 0);
    issue(CMD_MRS, 3'h0, 1'b0, 1'b0, RLC + 4 + 1);
    note("spacing");
    issue(CMD_REF, 3'h0, 1'b0, 1'b0, 0);
    issue(CMD_REF, 3'h0, 1'b0, 1'b0, 22);
    issue(CMD_ACT, 3'h4, 1'b0, 1'b0, 22);
    issue(CMD_REF, 3'h0, 1'b0, 1'b0, 0);
    n = 0;
    while (ref_due_q !== 1'b1 && n < 500)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("due_time", 1, n >= REFI - 2 && n <= REFI + 2);
    while (ref_urgent_q !== 1'b1 && n < 500)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("urgent_time", 1, n >= REFLIM - REFI - 2 && n <= REFLIM - REFI + 2);
    issue(CMD_REF, 3'h0, 1'b0, 1'b0, 0);
    @(posedge sys_clk);
    #1;
    chk("due_cleared", 0, ref_due_q);
    note("refresh");
    // refresh cycle time also holds off low-power entry; let it run out first
    repeat (20) @(posedge sys_clk);
    #1;
    pd_dll_off = 1'b1;
    issue(CMD_RD, 3'h4, 1'b0, 1'b0, 0);
    issue(CMD_PDE, 3'h0, 1'b0, 1'b0, RLC + 5);
    chk("cke_pd", 0, ddr_cke_q);
    issue(CMD_PDX, 3'h0, 1'b0, 1'b0, -3);
    issue(CMD_RD, 3'h4, 1'b0, 1'b0, -10);
    pd_dll_off = 1'b0;
    issue(CMD_WR, 3'h5, 1'b0, 1'b0, 0);
    issue(CMD_PDE, 3'h0, 1'b0, 1'b0, WLC + 4 + 3);
    issue(CMD_PDX, 3'h0, 1'b0, 1'b0, -3);
    issue(CMD_WR, 3'h5, 1'b1, 1'b0, -3);
    issue(CMD_PDE, 3'h0, 1'b0, 1'b0, WLC + 4 + 3 + 1);
    issue(CMD_PDX, 3'h0, 1'b0, 1'b0, -3);
    note("power_down");
    for (i = 0; i < 2; i++)
    begin
      issue(CMD_SRE, 3'h0, 1'b0, 1'b0, (i == 0) ? -3 : -2);
      chk("cke_sre", 0, ddr_cke_q);
      repeat (4)
      begin
        @(posedge sys_clk);
        #1;
        chk("clk_hold", 1, ddr_ck_en_q);
      end
      @(posedge sys_clk);
      #1;
      chk("clk_stop", 0, ddr_ck_en_q);
      issue(CMD_SRX, 3'h0, 1'b0, 1'b0, -4);
      chk("clk_restart", 1, ddr_ck_en_q);
      repeat (4)
      begin
        @(posedge sys_clk);
        #1;
        chk("cke_low_srx", 0, ddr_cke_q);
      end
      @(posedge sys_clk);
      #1;
      chk("cke_rise_srx", 1, ddr_cke_q);
      if (i == 0)
        issue(CMD_ACT, 3'h6, 1'b0, 1'b0, -(5 + 24));
      else
        issue(CMD_RD, 3'h6, 1'b0, 1'b0, -(5 + 512));
    end
    note("self_refresh");
    @(posedge sys_clk);
    #1;
    odt_req = 1'b1;
    @(posedge sys_clk);
    #1;
    odt_req = 1'b0;
    n = 0;
    repeat (20)
    begin
      @(negedge sys_clk);
      if (ddr_odt_q === 1'b1)
        n++;
    end
    chk("odt_high", 6, n);
    note("termination");
    repeat (4) @(posedge sys_clk);
    chk("model_violations", 0, bad_cnt);
    chk("notes_left", 0, q.size());
    results();
  end
endmodule
`default_nettype wire
